// ==== hdl/fxd_decoder.sv ====
// fxd_decoder: extension-instruction decoder of a numeric coprocessor
// assumes: host forwards whole escape instruction with a one-cycle valid,
//          then waits for done; one mclk per coprocessor clock
//
// Contract
// - addressing form 00, non-direct selector: no displacement bytes
// - form 01: one displacement byte, sign-extended to sixteen bits
// - form 11: selector is a stack-relative register index
// - selector 000 gives BX+SI+disp, 001 gives BX+DI+disp
// - form 00 selector 110: address is the sixteen-bit displacement
// - relative index i names register i below the top; zero is top
// - reverse bit orders subtract/divide operands; destination bit inverts it
// - register arithmetic with pop: five more clocks, pop after write
// - constant loads share a prefix; low bits pick constant; 11 to 24 clocks
// - memory addition fetch format from two-bit field; format-based clocks
// - memory multiply 110 to 168 clocks; register multiply 90 to 145
// - memory divide 215 to 243; register divide 193 to 203 before pop
// - scaling by next register, 32 to 38 clocks
// - partial remainder of top by next, 15 to 190 clocks
// - magnitude and sign flip, 10 to 17 clocks, differ in lowest bit
// - partial tangent of top, 30 to 540 clocks
// - partial arctangent of top and next, 250 to 800 clocks
// - enter protected, initialise, clear exceptions: 2 to 8 clocks
// - load control word reads sixteen bits at the address, 7 to 14 clocks
// - stack pointer increment/decrement by one, 6 to 12 clocks
`timescale 1ns/1ps
module fxd_decoder (
  input wire logic mclk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire fxd_pkg::fxd_instr_t instr,
  input wire fxd_pkg::fxd_regs_t regs,
  input wire logic [15:0] mem_rdata,
  output logic busy,
  output logic done,
  output fxd_pkg::fxd_dec_t dec_ff,
  output logic [2:0] stack_top_ff,
  output logic [15:0] control_word_ff
);
  import fxd_pkg::*;

  typedef enum logic [1:0] {
    FXD_IDLE,
    FXD_EXEC,
    FXD_FINISH
  } fxd_state_t;

  fxd_state_t state_ff;
  fxd_dec_t nxt_dec;
  logic [9:0] cnt_ff;
  logic done_ff;
  logic [1:0] mode;
  logic [2:0] sel;
  logic [2:0] mid;
  logic [2:0] lowb;
  logic [4:0] fixed_hi;
  logic is_reg;
  logic dbit;
  logic pbit;
  logic rbit;
  logic [1:0] disp_bytes;
  fxd_ea_t ea_form;
  logic [15:0] ea;
  logic [2:0] rel_idx;
  logic [2:0] rel_phys;
  logic [2:0] top;
  logic sp_push;
  logic sp_pop;
  logic sp_inc;
  logic sp_dec;
  logic sp_init;
  logic fin;

  assign lowb = instr.op1[FXD_OP1_MF_LSB - 1 +: 3];
  assign mode = instr.modrm[FXD_MOD_LSB +: 2];
  assign mid = instr.modrm[FXD_REG_LSB +: 3];
  assign sel = instr.modrm[FXD_RM_LSB +: 3];
  assign fixed_hi = instr.modrm[7:3];
  assign is_reg = (mode == FXD_MOD_REG);
  assign dbit = instr.op1[2];
  assign pbit = instr.op1[1];
  assign rbit = instr.modrm[3];
  assign rel_idx = sel;

  // ---------------------------------------------------------------
  // address generation and stack pointer
  // ---------------------------------------------------------------
  fxd_addr_gen u_addr (
    .instr(instr),
    .regs(regs),
    .disp_bytes(disp_bytes),
    .ea_form(ea_form),
    .ea(ea)
  );

  fxd_stack_ptr u_sp (
    .mclk(mclk),
    .rst(rst),
    .push(sp_push),
    .pop(sp_pop),
    .inc(sp_inc),
    .dec(sp_dec),
    .reinit(sp_init),
    .rel_idx(rel_idx),
    .top_ff(top),
    .rel_phys(rel_phys)
  );

  // ---------------------------------------------------------------
  // operation decode and clock ranges
  // ---------------------------------------------------------------
  always_comb begin
    nxt_dec = '0;
    nxt_dec.op = FXD_OP_NONE;
    nxt_dec.fmt = fxd_fmt_t'(instr.op1[FXD_OP1_MF_LSB +: 2]);
    nxt_dec.disp_bytes = is_reg ? 2'h0 : disp_bytes;
    nxt_dec.ea_form = ea_form;
    nxt_dec.ea = ea;
    nxt_dec.is_mem = !is_reg;
    nxt_dec.src_phys = top;
    nxt_dec.dst_phys = top;
    nxt_dec.const_sel = sel;
    nxt_dec.legal = 1'b1;
    if (!instr.op1[0] && !is_reg) begin
      // memory-form arithmetic with format field
      case (mid)
        3'h0: begin
          nxt_dec.op = FXD_OP_ADD;
          case (nxt_dec.fmt)
            FXD_MF_REAL32: {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd90, 10'd120};
            FXD_MF_INT32: {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd108, 10'd143};
            FXD_MF_REAL64: {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd95, 10'd125};
            default: {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd102, 10'd137};
          endcase
        end
        3'h1: begin
          nxt_dec.op = FXD_OP_MUL;
          case (nxt_dec.fmt)
            FXD_MF_REAL32: {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd110, 10'd125};
            FXD_MF_INT32: {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd130, 10'd144};
            FXD_MF_REAL64: {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd112, 10'd168};
            default: {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd124, 10'd138};
          endcase
        end
        3'h4, 3'h5: begin
          nxt_dec.op = FXD_OP_SUB;
          nxt_dec.reversed = rbit;
          case (nxt_dec.fmt)
            FXD_MF_REAL32: {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd90, 10'd120};
            FXD_MF_INT32: {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd108, 10'd143};
            FXD_MF_REAL64: {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd95, 10'd125};
            default: {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd102, 10'd137};
          endcase
        end
        3'h6, 3'h7: begin
          nxt_dec.op = FXD_OP_DIV;
          nxt_dec.reversed = rbit;
          case (nxt_dec.fmt)
            FXD_MF_REAL32: {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd215, 10'd225};
            FXD_MF_INT32: {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd230, 10'd243};
            FXD_MF_REAL64: {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd220, 10'd230};
            default: {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd224, 10'd238};
          endcase
        end
        default: nxt_dec.legal = 1'b0;
      endcase
    end else if (lowb[0] == 1'b0 && is_reg && mid[2:1] != 2'h1) begin
      // register-form arithmetic: d and p bits in first byte
      nxt_dec.pop = pbit;
      nxt_dec.dst_phys = dbit ? rel_phys : top;
      nxt_dec.src_phys = dbit ? top : rel_phys;
      case (mid)
        3'h0: begin
          nxt_dec.op = FXD_OP_ADD;
          {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd70, 10'd100};
        end
        3'h1: begin
          nxt_dec.op = FXD_OP_MUL;
          {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd90, 10'd145};
        end
        3'h4, 3'h5: begin
          nxt_dec.op = FXD_OP_SUB;
          nxt_dec.reversed = rbit ^ dbit;
          {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd70, 10'd100};
        end
        default: begin
          nxt_dec.op = FXD_OP_DIV;
          nxt_dec.reversed = rbit ^ dbit;
          {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd193, 10'd203};
        end
      endcase
      if (pbit) begin
        nxt_dec.clk_min = 10'(nxt_dec.clk_min + FXD_POP_PENALTY);
        nxt_dec.clk_max = 10'(nxt_dec.clk_max + FXD_POP_PENALTY);
      end
    end else if (lowb == FXD_OP1_MISC && is_reg) begin
      nxt_dec.is_mem = 1'b0;
      case (fixed_hi)
        FXD_CONST_PREFIX: begin
          nxt_dec.op = FXD_OP_CONST;
          case (sel)
            3'h0, 3'h2: {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd15, 10'd21};
            3'h1, 3'h3: {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd16, 10'd22};
            3'h4: {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd18, 10'd24};
            3'h5: {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd17, 10'd23};
            3'h6: {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd11, 10'd17};
            default: nxt_dec.legal = 1'b0;
          endcase
        end
        FXD_SIGN_PREFIX: begin
          nxt_dec.op = sel[0] ? FXD_OP_ABS : FXD_OP_CHS;
          {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd10, 10'd17};
          nxt_dec.legal = (sel[2:1] == 2'h0);
        end
        FXD_TRANS_PREFIX: begin
          case (sel)
            3'h2: begin
              nxt_dec.op = FXD_OP_PTAN;
              {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd30, 10'd540};
            end
            3'h3: begin
              nxt_dec.op = FXD_OP_PATAN;
              nxt_dec.src_phys = 3'(top + 3'h1);
              {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd250, 10'd800};
            end
            3'h6: begin
              nxt_dec.op = FXD_OP_DECSTP;
              {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd6, 10'd12};
            end
            3'h7: begin
              nxt_dec.op = FXD_OP_INCSTP;
              {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd6, 10'd12};
            end
            default: nxt_dec.legal = 1'b0;
          endcase
        end
        FXD_MATH_PREFIX: begin
          nxt_dec.src_phys = 3'(top + 3'h1);
          case (sel)
            3'h0: begin
              nxt_dec.op = FXD_OP_PREM;
              {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd15, 10'd190};
            end
            3'h5: begin
              nxt_dec.op = FXD_OP_SCALE;
              {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd32, 10'd38};
            end
            default: nxt_dec.legal = 1'b0;
          endcase
        end
        default: nxt_dec.legal = 1'b0;
      endcase
    end else if (lowb == FXD_OP1_CTRL && is_reg && fixed_hi == FXD_SIGN_PREFIX) begin
      {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd2, 10'd8};
      case (sel)
        3'h2: nxt_dec.op = FXD_OP_CLEX;
        3'h3: nxt_dec.op = FXD_OP_INIT;
        3'h4: nxt_dec.op = FXD_OP_SETPM;
        default: nxt_dec.legal = 1'b0;
      endcase
    end else if (lowb == FXD_OP1_MISC && !is_reg && mid == 3'h5) begin
      nxt_dec.op = FXD_OP_LDCW;
      {nxt_dec.clk_min, nxt_dec.clk_max} = {10'd7, 10'd14};
    end else begin
      nxt_dec.legal = 1'b0;
    end
    if (!nxt_dec.legal) begin
      nxt_dec.op = FXD_OP_NONE;
      nxt_dec.clk_min = 10'd1;
      nxt_dec.clk_max = 10'd1;
    end
  end

  // ---------------------------------------------------------------
  // decode capture
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dec_ff <= '0;
    end else if (instr_valid && state_ff == FXD_IDLE) begin
      dec_ff <= nxt_dec;
    end
  end

  // ---------------------------------------------------------------
  // execution sequencer: runs for the longest clock count
  // ---------------------------------------------------------------
  assign fin = (state_ff == FXD_EXEC) && (cnt_ff <= 10'd1);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= FXD_IDLE;
      cnt_ff <= 10'h000;
    end else begin
      case (state_ff)
        FXD_IDLE: begin
          if (instr_valid) begin
            state_ff <= FXD_EXEC;
            cnt_ff <= nxt_dec.clk_max;
          end
        end
        FXD_EXEC: begin
          cnt_ff <= cnt_ff - 10'h001;
          if (fin) begin
            state_ff <= FXD_FINISH;
          end
        end
        FXD_FINISH: state_ff <= FXD_IDLE;
        default: state_ff <= FXD_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= fin;
    end
  end

  // ---------------------------------------------------------------
  // stack effects at the end of execution, after the result write
  // ---------------------------------------------------------------
  assign sp_push = fin && dec_ff.op == FXD_OP_CONST;
  assign sp_pop = fin && dec_ff.pop;
  assign sp_inc = fin && dec_ff.op == FXD_OP_INCSTP;
  assign sp_dec = fin && dec_ff.op == FXD_OP_DECSTP;
  assign sp_init = fin && dec_ff.op == FXD_OP_INIT;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      control_word_ff <= 16'h0000;
    end else if (fin && dec_ff.op == FXD_OP_LDCW) begin
      control_word_ff <= mem_rdata;
    end
  end

  assign busy = (state_ff != FXD_IDLE);
  assign done = done_ff;
  assign stack_top_ff = top;

endmodule : fxd_decoder

// ==== hdl/fxd_pkg.sv ====
// fxd_pkg: shared types and constants of the coprocessor extension decoder
// assumes: one 100 MHz clock; decoded timings are in coprocessor clocks
package fxd_pkg;

  // ---------------------------------------------------------------
  // instruction field positions (first byte holds escape low bits)
  // ---------------------------------------------------------------
  localparam int unsigned FXD_OP1_MF_LSB = 1;
  localparam int unsigned FXD_MOD_LSB = 6;
  localparam int unsigned FXD_REG_LSB = 3;
  localparam int unsigned FXD_RM_LSB = 0;
  localparam logic [4:0] FXD_ESCAPE_CODE = 5'h1b;

  // ---------------------------------------------------------------
  // addressing-form and selector codes
  // ---------------------------------------------------------------
  localparam logic [1:0] FXD_MOD_NODISP = 2'h0;
  localparam logic [1:0] FXD_MOD_DISP8 = 2'h1;
  localparam logic [1:0] FXD_MOD_DISP16 = 2'h2;
  localparam logic [1:0] FXD_MOD_REG = 2'h3;
  localparam logic [2:0] FXD_RM_BX_SI = 3'h0;
  localparam logic [2:0] FXD_RM_BX_DI = 3'h1;
  localparam logic [2:0] FXD_RM_BP_SI = 3'h2;
  localparam logic [2:0] FXD_RM_BP_DI = 3'h3;
  localparam logic [2:0] FXD_RM_SI = 3'h4;
  localparam logic [2:0] FXD_RM_DI = 3'h5;
  localparam logic [2:0] FXD_RM_DIRECT = 3'h6;
  localparam logic [2:0] FXD_RM_BX = 3'h7;

  // ---------------------------------------------------------------
  // fixed first-byte low bits and constant, sign, transcendental and math prefixes
  // ---------------------------------------------------------------
  localparam logic [2:0] FXD_OP1_MISC = 3'h1;
  localparam logic [2:0] FXD_OP1_CTRL = 3'h3;
  localparam logic [4:0] FXD_CONST_PREFIX = 5'h1d;
  localparam logic [4:0] FXD_SIGN_PREFIX = 5'h1c;
  localparam logic [4:0] FXD_TRANS_PREFIX = 5'h1e;
  localparam logic [4:0] FXD_MATH_PREFIX = 5'h1f;

  // ---------------------------------------------------------------
  // timing constant and stack reset value
  // ---------------------------------------------------------------
  localparam logic [9:0] FXD_POP_PENALTY = 10'h005;
  localparam logic [3:0] FXD_RESET_STACK_TOP = 4'h0;

  typedef enum logic [1:0] {
    FXD_MF_REAL32,
    FXD_MF_INT32,
    FXD_MF_REAL64,
    FXD_MF_INT16
  } fxd_fmt_t;

  typedef enum logic [4:0] {
    FXD_OP_NONE,
    FXD_OP_ADD,
    FXD_OP_MUL,
    FXD_OP_SUB,
    FXD_OP_DIV,
    FXD_OP_CONST,
    FXD_OP_SCALE,
    FXD_OP_PREM,
    FXD_OP_ABS,
    FXD_OP_CHS,
    FXD_OP_PTAN,
    FXD_OP_PATAN,
    FXD_OP_INIT,
    FXD_OP_SETPM,
    FXD_OP_CLEX,
    FXD_OP_LDCW,
    FXD_OP_INCSTP,
    FXD_OP_DECSTP
  } fxd_op_t;

  typedef enum logic [2:0] {
    FXD_EA_NONE,
    FXD_EA_BX_SI,
    FXD_EA_BX_DI,
    FXD_EA_OTHER,
    FXD_EA_DIRECT
  } fxd_ea_t;

  // instruction as forwarded by the host
  typedef struct packed {
    logic [7:0] op1;
    logic [7:0] modrm;
    logic [7:0] disp_lo;
    logic [7:0] disp_hi;
  } fxd_instr_t;

  // address registers supplied by the host
  typedef struct packed {
    logic [15:0] bx;
    logic [15:0] si;
    logic [15:0] di;
  } fxd_regs_t;

  // full decode result
  typedef struct packed {
    fxd_op_t op;
    logic is_mem;
    fxd_fmt_t fmt;
    logic [1:0] disp_bytes;
    fxd_ea_t ea_form;
    logic [15:0] ea;
    logic [2:0] src_phys;
    logic [2:0] dst_phys;
    logic reversed;
    logic pop;
    logic [2:0] const_sel;
    logic [9:0] clk_min;
    logic [9:0] clk_max;
    logic legal;
  } fxd_dec_t;

endpackage : fxd_pkg

// ==== hdl/fxd_addr_gen.sv ====
// fxd_addr_gen: displacement length and effective address of a memory operand
// assumes: host supplies the address register values with the instruction
`timescale 1ns/1ps
module fxd_addr_gen (
  input wire fxd_pkg::fxd_instr_t instr,
  input wire fxd_pkg::fxd_regs_t regs,
  output logic [1:0] disp_bytes,
  output fxd_pkg::fxd_ea_t ea_form,
  output logic [15:0] ea
);
  import fxd_pkg::*;

  logic [1:0] mode;
  logic [2:0] sel;
  logic [15:0] disp;

  assign mode = instr.modrm[FXD_MOD_LSB +: 2];
  assign sel = instr.modrm[FXD_RM_LSB +: 3];

  // ---------------------------------------------------------------
  // displacement
  // ---------------------------------------------------------------
  always_comb begin
    disp = 16'h0000;
    disp_bytes = 2'h0;
    case (mode)
      FXD_MOD_NODISP: begin
        if (sel == FXD_RM_DIRECT) begin
          disp = {instr.disp_hi, instr.disp_lo};
          disp_bytes = 2'h2;
        end else begin
          disp = 16'h0000;
          disp_bytes = 2'h0;
        end
      end
      FXD_MOD_DISP8: begin
        disp = {{8{instr.disp_lo[7]}}, instr.disp_lo};
        disp_bytes = 2'h1;
      end
      FXD_MOD_DISP16: begin
        disp = {instr.disp_hi, instr.disp_lo};
        disp_bytes = 2'h2;
      end
      default: begin
        disp = 16'h0000;
        disp_bytes = 2'h0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // effective address
  // ---------------------------------------------------------------
  always_comb begin
    ea = 16'h0000;
    ea_form = FXD_EA_NONE;
    if (mode == FXD_MOD_REG) begin
      ea_form = FXD_EA_NONE;
    end else if (mode == FXD_MOD_NODISP && sel == FXD_RM_DIRECT) begin
      ea_form = FXD_EA_DIRECT;
      ea = disp;
    end else begin
      case (sel)
        FXD_RM_BX_SI: begin
          ea_form = FXD_EA_BX_SI;
          ea = 16'(regs.bx + regs.si + disp);
        end
        FXD_RM_BX_DI: begin
          ea_form = FXD_EA_BX_DI;
          ea = 16'(regs.bx + regs.di + disp);
        end
        FXD_RM_SI: begin
          ea_form = FXD_EA_OTHER;
          ea = 16'(regs.si + disp);
        end
        FXD_RM_DI: begin
          ea_form = FXD_EA_OTHER;
          ea = 16'(regs.di + disp);
        end
        FXD_RM_BX: begin
          ea_form = FXD_EA_OTHER;
          ea = 16'(regs.bx + disp);
        end
        default: begin
          ea_form = FXD_EA_OTHER;
          ea = disp;
        end
      endcase
    end
  end

endmodule : fxd_addr_gen

// ==== hdl/fxd_stack_ptr.sv ====
// fxd_stack_ptr: three-bit stack top pointer and relative register mapping
// assumes: at most one adjust request per cycle
`timescale 1ns/1ps
module fxd_stack_ptr (
  input wire logic mclk,
  input wire logic rst,
  input wire logic push,
  input wire logic pop,
  input wire logic inc,
  input wire logic dec,
  input wire logic reinit,
  input wire logic [2:0] rel_idx,
  output logic [2:0] top_ff,
  output logic [2:0] rel_phys
);
  import fxd_pkg::*;

  logic [2:0] nxt_top;

  // ---------------------------------------------------------------
  // pointer update, wraps modulo eight
  // ---------------------------------------------------------------
  always_comb begin
    nxt_top = top_ff;
    if (reinit) begin
      nxt_top = FXD_RESET_STACK_TOP[2:0];
    end else if (push || dec) begin
      nxt_top = 3'(top_ff - 3'h1);
    end else if (pop || inc) begin
      nxt_top = 3'(top_ff + 3'h1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      top_ff <= FXD_RESET_STACK_TOP[2:0];
    end else begin
      top_ff <= nxt_top;
    end
  end

  // relative index counts down from the top; index zero is the top
  assign rel_phys = 3'(top_ff + rel_idx);

endmodule : fxd_stack_ptr

// ==== tb/fxd_host_model.sv ====
// fxd_host_model: host that forwards escape instructions to the decoder
// assumes: bench pulses go for one cycle with the instruction in req
`timescale 1ns/1ps
module fxd_host_model #(
  parameter logic [47:0] REGS = 48'h1000_0200_0030,
  parameter logic [15:0] CWORD = 16'h037f
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic go,
  input wire fxd_pkg::fxd_instr_t req,
  input wire logic busy,
  output logic instr_valid,
  output fxd_pkg::fxd_instr_t instr,
  output fxd_pkg::fxd_regs_t regs,
  output logic [15:0] mem_rdata
);
  import fxd_pkg::*;
  assign regs = REGS;
  assign mem_rdata = CWORD;
  // whole instruction offered at once, scrambled once taken
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      instr_valid <= 1'b0;
      instr <= '0;
    end else if (go) begin
      instr_valid <= 1'b1;
      instr <= req;
    end else if (instr_valid && !busy) begin
      instr_valid <= 1'b0;
      instr <= ~instr;
    end
  end
endmodule : fxd_host_model

// ==== tb/fxd_decoder_monitor.sv ====
// fxd_decoder_monitor: port assertions of the decoder
// assumes: bound to fxd_decoder, single clock domain
`timescale 1ns/1ps
module fxd_decoder_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire fxd_pkg::fxd_instr_t instr,
  input wire fxd_pkg::fxd_regs_t regs,
  input wire logic [15:0] mem_rdata,
  input wire logic busy,
  input wire logic done,
  input wire fxd_pkg::fxd_dec_t dec_ff,
  input wire logic [2:0] stack_top_ff,
  input wire logic [15:0] control_word_ff
);
  import fxd_pkg::*;
  logic [10:0] cnt_ff;
  logic take;
  assign take = instr_valid && !busy;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // cycles since the last accept
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 11'h0;
    end else begin
      cnt_ff <= take ? 11'h1 : cnt_ff + 11'h1;
    end
  end
  nodisp_len_a: assert property (
    take && instr.modrm[7:6] == 2'h0 && instr.modrm[2:0] != 3'h6
    |=> dec_ff.disp_bytes == 2'h0) else $error("no-displacement length wrong");
  short_disp_a: assert property (
    take && instr.modrm[7:6] == 2'h1 && instr.modrm[2:0] == 3'h0
    |=> dec_ff.disp_bytes == 2'h1 && dec_ff.ea == $past(regs.bx) + $past(regs.si)
      + {{8{$past(instr.disp_lo[7])}}, $past(instr.disp_lo)}) else $error("short form wrong");
  direct_addr_a: assert property (
    take && instr.modrm[7:6] == 2'h0 && instr.modrm[2:0] == 3'h6
    |=> dec_ff.ea == {$past(instr.disp_hi), $past(instr.disp_lo)}) else $error("direct wrong");
  reg_select_a: assert property (
    take && !instr.op1[0] && instr.modrm[7:6] == 2'h3 && instr.modrm[5:4] != 2'h1
    |=> !dec_ff.is_mem && (dec_ff.src_phys == $past(stack_top_ff) + $past(instr.modrm[2:0])
      || dec_ff.dst_phys == $past(stack_top_ff) + $past(instr.modrm[2:0])))
    else $error("register index wrong");
  reverse_bit_a: assert property (
    take && !instr.op1[0] && instr.modrm[7:6] == 2'h3 && instr.modrm[5]
    |=> dec_ff.reversed == ($past(instr.modrm[3]) ^ $past(instr.op1[2])))
    else $error("reverse sense wrong");
  pop_clocks_a: assert property (
    take && !instr.op1[0] && instr.modrm[7:3] == 5'h18
    |=> dec_ff.clk_max == ($past(instr.op1[1]) ? 10'h069 : 10'h064)) else $error("add time wrong");
  pop_step_a: assert property (
    done && dec_ff.pop |-> stack_top_ff == $past(stack_top_ff) + 3'h1) else $error("pop wrong");
  push_const_a: assert property (
    done && dec_ff.op == FXD_OP_CONST |-> stack_top_ff == $past(stack_top_ff) - 3'h1)
    else $error("push wrong");
  cw_load_a: assert property (
    done && dec_ff.op == FXD_OP_LDCW |-> control_word_ff == $past(mem_rdata))
    else $error("control word wrong");
  done_time_a: assert property (
    done |-> cnt_ff == {1'b0, dec_ff.clk_max} + 11'h1) else $error("done at wrong cycle");
endmodule : fxd_decoder_monitor
bind fxd_decoder fxd_decoder_monitor u_mon (.mclk, .rst, .instr_valid, .instr, .regs,
  .mem_rdata, .busy, .done, .dec_ff, .stack_top_ff, .control_word_ff);

// ==== tb/tb.sv ====
// tb: self-checking bench of the extension decoder
// assumes: host model in front, checker bound to the decoder
`timescale 1ns/1ps
module tb;
  import fxd_pkg::*;
  localparam logic [15:0] BX = 16'h1000, SI = 16'h0200, DI = 16'h0030, CW = 16'h037f;
  logic mclk, rst, go, instr_valid, busy, done;
  fxd_instr_t req, instr;
  fxd_regs_t regs;
  fxd_dec_t dec;
  logic [15:0] mem_rdata, cw;
  logic [2:0] top;
  int bad_count, cmp_count, cyc, k;
  fxd_host_model #(.REGS({BX, SI, DI}), .CWORD(CW)) host (.mclk(mclk), .rst(rst), .go(go),
    .req(req), .busy(busy), .instr_valid(instr_valid), .instr(instr), .regs(regs),
    .mem_rdata(mem_rdata));
  fxd_decoder dut (.mclk(mclk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .regs(regs), .mem_rdata(mem_rdata), .busy(busy), .done(done), .dec_ff(dec),
    .stack_top_ff(top), .control_word_ff(cw));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic test_done();
    if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // offer one instruction, count cycles from the offer to done
  task automatic run(input logic [7:0] o, input logic [7:0] m, input logic [7:0] lo,
    input logic [7:0] hi);
    @(posedge mclk);
    go <= 1'b1;
    req <= {o, m, lo, hi};
    @(posedge mclk);
    go <= 1'b0;
    @(negedge mclk);
    k = 0;
    while (done !== 1'b1 && k < 1000) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 1000) bad_count++;
    chk("busy", busy, 1'b1);
  endtask : run
  task automatic xrun(input logic [7:0] o, input logic [7:0] m, input fxd_op_t op, int n);
    run(o, m, 8'h5a, 8'ha5);
    chk("op", dec.op, op);
    chk("cycles", k, n + 1);
  endtask : xrun
  task automatic t_const();
    xrun(8'hd9, 8'hee, FXD_OP_CONST, 17);
    chk("top", top, 3'h7);
    xrun(8'hd9, 8'he8, FXD_OP_CONST, 21);
    xrun(8'hd9, 8'hec, FXD_OP_CONST, 24);
    chk("top", top, 3'h5);
  endtask : t_const
  task automatic t_unary();
    xrun(8'hd9, 8'he1, FXD_OP_ABS, 17);
    xrun(8'hd9, 8'he0, FXD_OP_CHS, 17);
    xrun(8'hd9, 8'hfd, FXD_OP_SCALE, 38);
    xrun(8'hd9, 8'hf8, FXD_OP_PREM, 190);
    xrun(8'hd9, 8'hf2, FXD_OP_PTAN, 540);
    xrun(8'hd9, 8'hf3, FXD_OP_PATAN, 800);
  endtask : t_unary
  task automatic t_ctrl();
    xrun(8'hd9, 8'hf7, FXD_OP_INCSTP, 12);
    chk("top", top, 3'h6);
    xrun(8'hd9, 8'hf6, FXD_OP_DECSTP, 12);
    chk("top", top, 3'h5);
    xrun(8'hdb, 8'he3, FXD_OP_INIT, 8);
    xrun(8'hdb, 8'he4, FXD_OP_SETPM, 8);
    xrun(8'hdb, 8'he2, FXD_OP_CLEX, 8);
  endtask : t_ctrl
  task automatic t_mem();
    run(8'hd8, 8'h40, 8'h80, 8'h11);
    chk("cycles", k, 121);
    chk("bytes", dec.disp_bytes, 2'h1);
    chk("ea", dec.ea, 16'(BX + SI + 16'hff80));
    run(8'hda, 8'h01, 8'h77, 8'h66);
    chk("fmt", dec.fmt, FXD_MF_INT32);
    chk("bytes", dec.disp_bytes, 2'h0);
    chk("ea", dec.ea, BX + DI);
    run(8'hdc, 8'h01, 8'h00, 8'h00);
    chk("cycles", k, 126);
    run(8'hde, 8'h01, 8'h00, 8'h00);
    chk("fmt", dec.fmt, FXD_MF_INT16);
    xrun(8'hd8, 8'hc9, FXD_OP_MUL, 145);
    xrun(8'hd8, 8'h08, FXD_OP_MUL, 125);
    xrun(8'hd8, 8'h30, FXD_OP_DIV, 225);
  endtask : t_mem
  task automatic t_ldcw();
    xrun(8'hd9, 8'h2e, FXD_OP_LDCW, 14);
    run(8'hd9, 8'h2e, 8'h34, 8'h12);
    chk("ea", dec.ea, 16'h1234);
    chk("cw", cw, CW);
  endtask : t_ldcw
  task automatic t_reg();
    xrun(8'hda, 8'hc3, FXD_OP_ADD, 105);
    chk("src", dec.src_phys, 3'h3);
    chk("top", top, 3'h1);
    xrun(8'hdc, 8'hf9, FXD_OP_DIV, 203);
    chk("rev", dec.reversed, 1'b0);
    chk("dst", dec.dst_phys, 3'h2);
    xrun(8'hd8, 8'he9, FXD_OP_SUB, 100);
    chk("rev", dec.reversed, 1'b1);
  endtask : t_reg
  initial begin
    rst = 1'b1;
    go = 1'b0;
    req = '0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    t_const();
    t_unary();
    t_ctrl();
    t_mem();
    t_ldcw();
    t_reg();
    test_done();
  end
endmodule : tb
